// ---- rtl/dpr_pkg.sv ----
package dpr_pkg;
    // memory geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 9;
    // clock period in picoseconds (40 MHz)
    localparam int CLK_PS = 25000;
    // device timing figures in ns
    localparam int T_ADDR_ACCESS_NS = 35;
    localparam int T_OE_ACCESS_NS = 20;
    localparam int T_WRITE_PULSE_NS = 30;
    localparam int T_WRITE_TO_HIZ_NS = 15;
    localparam int T_DATA_VALID_NS = 25;
    localparam int T_ADDR_SETUP_NS = 0;
    localparam int T_WRITE_RECOVERY_NS = 2;
    localparam int T_HIGH_Z_NS = 15;
    localparam int T_WRITE_DATA_HOLD_NS = 0;
    // least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
    localparam int CYC_READ = ns_to_cyc(T_ADDR_ACCESS_NS);
    localparam int CYC_SETUP = ns_to_cyc(T_ADDR_SETUP_NS);
    localparam int CYC_WP_OE_HI = ns_to_cyc(T_WRITE_PULSE_NS);
    localparam int CYC_WP_OE_LO_A = ns_to_cyc(T_WRITE_TO_HIZ_NS
        + T_DATA_VALID_NS);
    localparam int CYC_WP_OE_LO = (CYC_WP_OE_LO_A > CYC_WP_OE_HI)
        ? CYC_WP_OE_LO_A : CYC_WP_OE_HI;
    localparam int CYC_HIZ = ns_to_cyc(T_WRITE_TO_HIZ_NS);
    localparam int CYC_RECOVER = ns_to_cyc(T_WRITE_RECOVERY_NS);
    localparam int CYC_TURN = ns_to_cyc(T_HIGH_Z_NS);
    localparam int CYC_HOLD = ns_to_cyc(T_WRITE_DATA_HOLD_NS);
    localparam int CNT_W = 4;
    // host sequencer states
    typedef enum logic [2:0] {
        DPR_IDLE = 3'b000,
        DPR_SETUP = 3'b001,
        DPR_RD_WAIT = 3'b010,
        DPR_WR_HIZ = 3'b011,
        DPR_WR_PULSE = 3'b100,
        DPR_WR_HOLD = 3'b101,
        DPR_TURN = 3'b110
    } dpr_state_t;
endpackage : dpr_pkg

// ---- rtl/dpr_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for the data lines coming back from the memory
module dpr_sync
    import dpr_pkg::*;
#(
    parameter int WIDTH = 9
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb
    begin
        next_meta = async_in;
        next_sync = meta;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule : dpr_sync

// ---- rtl/dpr_host.sv ----
`timescale 1ns/1ps
module dpr_host
    import dpr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
)
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // user request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_keep_oe_in,
    input wire logic [AW-1:0] req_addr_in,
    input wire logic [DW-1:0] req_wdata_in,
    output logic req_ready_out,
    // user answer
    output logic rsp_valid_out,
    output logic [DW-1:0] rsp_rdata_out,
    // memory port pins
    output logic [AW-1:0] mem_addr_out,
    output logic mem_rw_out,
    output logic mem_oe_n_out,
    input wire logic [DW-1:0] port_data_bus_in,
    output logic [DW-1:0] port_data_bus_out,
    output logic port_data_bus_oe_out
);
    dpr_state_t state;
    dpr_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [AW-1:0] next_addr;
    logic next_rw;
    logic next_oe_n;
    logic [DW-1:0] next_dout;
    logic next_doe;
    logic next_rsp_valid;
    logic [DW-1:0] next_rdata;
    logic keep_oe;
    logic next_keep_oe;
    logic is_write;
    logic next_is_write;
    logic [DW-1:0] data_sync;

    // pin data is asynchronous to sys_clk_in
    dpr_sync #(
        .WIDTH(DW)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(port_data_bus_in),
        .sync_out(data_sync)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n);
    endfunction : cyc

    assign req_ready_out = (state == DPR_IDLE);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_addr = mem_addr_out;
        next_rw = mem_rw_out;
        next_oe_n = mem_oe_n_out;
        next_dout = port_data_bus_out;
        next_doe = port_data_bus_oe_out;
        next_rsp_valid = 1'b0;
        next_rdata = rsp_rdata_out;
        next_keep_oe = keep_oe;
        next_is_write = is_write;
        if (cnt != '0)
        begin
            next_cnt = cnt - 1'b1;
        end
        case (state)
            DPR_IDLE:
            begin
                if (req_valid_in)
                begin
                    next_addr = req_addr_in;
                    next_rw = 1'b1;
                    next_is_write = req_write_in;
                    next_keep_oe = req_keep_oe_in;
                    next_dout = req_wdata_in;
                    // enable held off until address settles
                    next_oe_n = 1'b1;
                    next_cnt = cyc(CYC_SETUP);
                    next_state = DPR_SETUP;
                end
            end
            DPR_SETUP:
            begin
                if (cnt == '0)
                begin
                    if (is_write)
                    begin
                        next_rw = 1'b0;
                        next_oe_n = !keep_oe;
                        next_cnt = cyc(CYC_HIZ);
                        next_state = DPR_WR_HIZ;
                    end
                    else
                    begin
                        next_oe_n = 1'b0;
                        // two extra cycles cover the synchroniser
                        next_cnt = cyc(CYC_READ + 2);
                        next_state = DPR_RD_WAIT;
                    end
                end
            end
            DPR_RD_WAIT:
            begin
                if (cnt == '0)
                begin
                    next_rdata = data_sync;
                    next_rsp_valid = 1'b1;
                    // release enable to tristate the memory
                    next_oe_n = 1'b1;
                    next_cnt = cyc(CYC_TURN);
                    next_state = DPR_TURN;
                end
            end
            DPR_WR_HIZ:
            begin
                if (cnt == '0)
                begin
                    // drive only after memory outputs are off
                    next_doe = 1'b1;
                    // when enable stays low the pulse count is CYC_WP_OE_LO less the CYC_HIZ already spent, shorter here
                    next_cnt = keep_oe ? cyc(CYC_WP_OE_LO - CYC_HIZ)
                        : cyc(CYC_WP_OE_HI);
                    next_state = DPR_WR_PULSE;
                end
            end
            DPR_WR_PULSE:
            begin
                if (cnt == '0)
                begin
                    next_rw = 1'b1;
                    next_oe_n = 1'b1;
                    next_cnt = cyc(CYC_HOLD);
                    next_state = DPR_WR_HOLD;
                end
            end
            DPR_WR_HOLD:
            begin
                // data held past the write end
                if (cnt == '0)
                begin
                    next_doe = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_cnt = cyc(CYC_RECOVER);
                    next_state = DPR_TURN;
                end
            end
            DPR_TURN:
            begin
                if (cnt == '0)
                begin
                    next_state = DPR_IDLE;
                end
            end
            default:
            begin
                next_state = DPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= DPR_IDLE;
            cnt <= '0;
            mem_addr_out <= '0;
            mem_rw_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            port_data_bus_out <= '0;
            port_data_bus_oe_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
            keep_oe <= 1'b0;
            is_write <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            mem_addr_out <= next_addr;
            mem_rw_out <= next_rw;
            mem_oe_n_out <= next_oe_n;
            port_data_bus_out <= next_dout;
            port_data_bus_oe_out <= next_doe;
            rsp_valid_out <= next_rsp_valid;
            rsp_rdata_out <= next_rdata;
            keep_oe <= next_keep_oe;
            is_write <= next_is_write;
        end
    end

    sequence s_wr_start;
        $fell(mem_rw_out);
    endsequence

    AST_ADDR_RW_HIGH: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) $changed(mem_addr_out) |-> mem_rw_out)
        else $error("address changed while write select low");
    AST_ADDR_STABLE_WR: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) !mem_rw_out |-> $stable(mem_addr_out))
        else $error("address moved during write");
    AST_NO_EARLY_DRIVE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) s_wr_start |-> !port_data_bus_oe_out [*1])
        else $error("data driven at write start");
    AST_NO_CONTEND: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !(port_data_bus_oe_out && mem_rw_out && !mem_oe_n_out))
        else $error("host drives while memory reads out");
    AST_WP_MIN: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) s_wr_start |-> !mem_rw_out [*2])
        else $error("write pulse too short");
    AST_HOLD: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(mem_rw_out) |->
        port_data_bus_oe_out && $stable(port_data_bus_out))
        else $error("write data released before hold");
    AST_ADDR_BEFORE_OE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in) $fell(mem_oe_n_out) |-> $stable(mem_addr_out))
        else $error("enable fell with address moving");
    AST_RD_DONE: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        ($fell(mem_oe_n_out) && mem_rw_out) |-> ##[1:8] rsp_valid_out)
        else $error("read answer late");
endmodule : dpr_host

// ---- testbench/dpr_mem_model.sv ----
`timescale 1ns/1ps
// behavioural two-port word array; index 0 is left, 1 is right
module dpr_mem_model
    import dpr_pkg::*;
#(
    parameter int ACC_NS = 20
)
(
    // pins of both ports
    input wire logic [1:0][ADDR_W-1:0] addr_in,
    input wire logic [1:0] rw_in,
    input wire logic [1:0] oe_n_in,
    input wire logic [1:0][DATA_W-1:0] data_in,
    output wire logic [1:0][DATA_W-1:0] data_out,
    output wire logic [1:0] drive_out
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        always @*
        begin
            if (rw_in[p] === 1'b0)
                cells[addr_in[p]] = data_in[p];
        end
        assign #(ACC_NS) data_out[p] = cells[addr_in[p]];
        assign drive_out[p] = rw_in[p] && !oe_n_in[p];
    end
endmodule : dpr_mem_model

// ---- testbench/async_dual_port_ram_tb.sv ----
`timescale 1ns/1ps
module async_dual_port_ram_tb;
    import dpr_pkg::*;
    localparam int DV_C = (T_DATA_VALID_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WP_C = (T_WRITE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WL_C = ((T_WRITE_TO_HIZ_NS + T_DATA_VALID_NS) * 1000
        + CLK_PS - 1) / CLK_PS;
    // with enable kept low the pulse must cover the larger of both limits
    localparam int WK_C = (WL_C > WP_C) ? WL_C : WP_C;
    logic sys_clk_in;
    logic rst_n_in;
    logic [1:0] vld = '0;
    logic [1:0] wr = '0;
    logic [1:0] kp = '0;
    logic [1:0][ADDR_W-1:0] ad = '0;
    logic [1:0][DATA_W-1:0] wd = '0;
    wire [1:0] rdy, rv, rw, oe, ho, mv;
    wire [1:0][DATA_W-1:0] rd, hd, md, bus;
    wire [1:0][ADDR_W-1:0] ma;
    logic [1:0][DATA_W-1:0] lb = '0;
    logic [1:0][ADDR_W-1:0] pa = '0;
    int lo [2] = '{0, 0};
    int dv [2] = '{0, 0};
    logic [1:0] kept = '0;
    // unwritten words stay unknown here and in the model, so a read of one is not flagged
    logic [DATA_W-1:0] ref_mem [0:(1<<ADDR_W)-1];
    int n_fail = 0;
    int checks = 0;
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        dpr_host dpr_host_i (
            .sys_clk_in(sys_clk_in),
            .rst_n_in(rst_n_in),
            .req_valid_in(vld[p]),
            .req_write_in(wr[p]),
            .req_keep_oe_in(kp[p]),
            .req_addr_in(ad[p]),
            .req_wdata_in(wd[p]),
            .req_ready_out(rdy[p]),
            .rsp_valid_out(rv[p]),
            .rsp_rdata_out(rd[p]),
            .mem_addr_out(ma[p]),
            .mem_rw_out(rw[p]),
            .mem_oe_n_out(oe[p]),
            .port_data_bus_in(bus[p]),
            .port_data_bus_out(hd[p]),
            .port_data_bus_oe_out(ho[p])
        );
        // a released line flips every cycle rather than keep its value
        assign bus[p] = ho[p] ? hd[p] : (mv[p] ? md[p] : ~lb[p]);
    end
    // slowest access time, the figure the host timing is built for
    dpr_mem_model #(
        .ACC_NS(T_ADDR_ACCESS_NS)
    ) dpr_mem_model_i (
        .addr_in(ma),
        .rw_in(rw),
        .oe_n_in(oe),
        .data_in(bus),
        .data_out(md),
        .drive_out(mv)
    );
    initial
    begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string nm, input logic [11:0] s, e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic test_done();
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    function automatic logic [DATA_W-1:0] exp_rd(input logic [11:0] a);
        return ref_mem[a];
    endfunction : exp_rd
    // pin watch on both ports
    always @(negedge sys_clk_in)
    begin
        for (int p = 0; p < 2; p++)
        begin
            lb[p] <= bus[p];
            pa[p] <= ma[p];
            if (rst_n_in)
            begin
                check("contention", 12'(ho[p] & mv[p]), 12'h0);
                check("addr_move", 12'((!rw[p] || !oe[p]) && ma[p] !== pa[p]),
                    12'h0);
                if (!rw[p])
                begin
                    lo[p]++;
                    dv[p] += int'(ho[p]);
                    kept[p] = kept[p] | !oe[p];
                end
                else if (lo[p] > 0)
                begin
                    check("pulse", 12'(lo[p] >= (kept[p] ? WK_C : WP_C)),
                        12'h1);
                    check("data_valid", 12'(dv[p] >= DV_C), 12'h1);
                    check("hold", 12'(ho[p]), 12'h1);
                    lo[p] = 0;
                    dv[p] = 0;
                    kept[p] = 1'b0;
                end
            end
        end
    end
    task automatic op(input int p, input logic w, k, input logic [11:0] a,
        input logic [8:0] d);
        int n;
        n = 0;
        @(negedge sys_clk_in);
        while (rdy[p] !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        vld[p] = 1'b1;
        wr[p] = w;
        kp[p] = k;
        ad[p] = a;
        wd[p] = d;
        @(negedge sys_clk_in);
        vld[p] = 1'b0;
        n = 0;
        while (rv[p] !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk_in);
            n++;
        end
        check("answer", 12'(n < 20), 12'h1);
        if (w)
            ref_mem[a] = d;
        else
            check("rdata", 12'(rd[p]), 12'(exp_rd(a)));
    endtask : op
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        n_fail++;
        test_done();
    end
    initial
    begin
        int s;
        logic [11:0] a;
        logic [8:0] d;
        s = $urandom(68);
        rst_n_in = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        check("rst_ready", 12'(rdy), 12'h3);
        check("rst_pins", 12'({rw, oe, ho}), 12'h3C);
        rst_n_in = 1'b1;
        // boundary words written on one side, read on the other
        for (int i = 0; i < 4; i++)
        begin
            a = (i < 2) ? 12'h000 : 12'hFFF;
            d = (i < 2) ? 9'h1FF : 9'h000;
            op(i % 2, 1'b1, 1'(i == 1 || i == 2), a, d);
            op(1 - i % 2, 1'b0, 1'b0, a, 9'h000);
        end
        for (int i = 0; i < 40; i++)
        begin
            s = int'($urandom % 2);
            a = 12'($urandom);
            d = 9'($urandom);
            op(s, 1'b1, 1'($urandom), a, d);
            op(1 - s, 1'b0, 1'b0, a, 9'h000);
            op(s, 1'b0, 1'b0, a, 9'h000);
        end
        // both hosts busy, never on one location
        for (int i = 0; i < 10; i++)
        begin
            a = 12'($urandom);
            d = 9'($urandom);
            fork
                op(0, 1'b1, 1'b0, a, d);
                op(1, 1'b1, 1'b1, a ^ 12'h800, ~d);
            join
            fork
                op(0, 1'b0, 1'b0, a ^ 12'h800, 9'h000);
                op(1, 1'b1, 1'b0, a, d + 9'h001);
            join
            op(0, 1'b0, 1'b0, a, 9'h000);
        end
        test_done();
    end
endmodule : async_dual_port_ram_tb
